// >>> shared/mpsc_pkg.sv
// What this block does
// - host holds key low five seconds to power on
// - key low five seconds leaves deep sleep early
// - key low three seconds when on powers off
// - orderly power-off sends detach request first
// - power monitor high whenever on, software cannot clear
// - monitor low when off; host watches it
// - aux supply off in deep sleep when enabled
// - hard shutdown low holds module in reset
// - hard shutdown release turns off without detach
// - host holds hard shutdown low 200 ms
// - hard shutdown ignored unless monitor is high
// - module drives own power-on reset on shutdown line
// - host drives key line open-drain, no pull-up
// - shutdown line pulled up inside, host open-collector
// - off state may only go to on
// - host powers on only with supply above 3.20 V
// - power saving: down on timer, up at wake-up
// - host uses hard shutdown only for emergencies
package mpsc_pkg;

   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned ON_MS          = 5000;
   localparam int unsigned OFF_MS         = 3000;
   localparam int unsigned HSD_MS         = 200;
   localparam int unsigned POR_MS         = 10;
   localparam int unsigned DETACH_MS      = 1000;
   localparam int unsigned MARGIN_MS      = 500;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned ON_CYC         = ON_MS * CYC_PER_MS;
   localparam int unsigned OFF_CYC        = OFF_MS * CYC_PER_MS;
   localparam int unsigned HSD_CYC        = HSD_MS * CYC_PER_MS;
   localparam int unsigned POR_CYC        = POR_MS * CYC_PER_MS;
   localparam int unsigned DETACH_CYC     = DETACH_MS * CYC_PER_MS;
   localparam int unsigned MARGIN_CYC     = MARGIN_MS * CYC_PER_MS;
   localparam int unsigned CNT_W          = 32;

   typedef enum logic [2:0]
   {
      MPSC_OFF    = 3'b000,
      MPSC_POR    = 3'b001,
      MPSC_ON     = 3'b010,
      MPSC_DETACH = 3'b011,
      MPSC_PSM    = 3'b100,
      MPSC_RESET  = 3'b101
   } mpsc_state_t;

   typedef enum logic [1:0]
   {
      MPSC_H_IDLE = 2'b00,
      MPSC_H_KEY  = 2'b01,
      MPSC_H_HSD  = 2'b10
   } mpsc_host_state_t;

endpackage

// >>> shared/mpsc_if.sv
`timescale 1ns/1ps
interface mpsc_if;
   // power key / wake line, open drain
   logic key_host_o;
   logic key_host_oe;
   // hard shutdown line, open collector; module drives it during power-on reset
   logic hard_shutdown_n_host_o;
   logic hard_shutdown_n_host_oe;
   logic hard_shutdown_n_dev_o;
   logic hard_shutdown_n_dev_oe;
   // module outputs
   logic power_monitor_out;
   logic aux_supply_out;
   // resolved wire levels, internal pull-ups
   logic key_n;
   logic hard_shutdown_n;

   assign key_n           = (key_host_oe && !key_host_o) ? 1'b0 : 1'b1;
   assign hard_shutdown_n = ((hard_shutdown_n_host_oe && !hard_shutdown_n_host_o)
                          || (hard_shutdown_n_dev_oe && !hard_shutdown_n_dev_o)) ? 1'b0 : 1'b1;

   modport device
   (
      input  key_n,
      input  hard_shutdown_n,
      output hard_shutdown_n_dev_o,
      output hard_shutdown_n_dev_oe,
      output power_monitor_out,
      output aux_supply_out
   );

   modport host
   (
      input  key_n,
      input  hard_shutdown_n,
      input  power_monitor_out,
      input  aux_supply_out,
      output key_host_o,
      output key_host_oe,
      output hard_shutdown_n_host_o,
      output hard_shutdown_n_host_oe
   );
endinterface

// >>> src/mpsc_device.sv
`timescale 1ns/1ps
module mpsc_device #(
   parameter int unsigned ON_CYC     = mpsc_pkg::ON_CYC,
   parameter int unsigned OFF_CYC    = mpsc_pkg::OFF_CYC,
   parameter int unsigned POR_CYC    = mpsc_pkg::POR_CYC,
   parameter int unsigned DETACH_CYC = mpsc_pkg::DETACH_CYC
)(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // pins
   mpsc_if.device    pins,
   // user side
   input  wire logic software_shutdown_command,
   input  wire logic psm_enable,
   input  wire logic psm_timer_expired,
   input  wire logic psm_wake_due,
   input  wire logic sleep_request,
   output logic      detach_request,
   output logic      in_reset,
   output logic      in_sleep,
   output logic      in_psm
);

   mpsc_pkg::mpsc_state_t  state_q, state_d;
   logic [mpsc_pkg::CNT_W-1:0] key_cnt_q, key_cnt_d;
   logic [mpsc_pkg::CNT_W-1:0] tmr_q, tmr_d;
   logic                   sleep_q, sleep_d;
   logic                   mon_q, mon_d;
   logic                   aux_q, aux_d;
   logic                   det_q, det_d;
   logic                   rst_q, rst_d;
   logic                   por_oe_q, por_oe_d;
   logic                   psm_q, psm_d;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // last cycle of a count of lim cycles; lim must be at least 1
   function automatic logic reached
   (
      input logic [mpsc_pkg::CNT_W-1:0] cnt,
      input int unsigned                lim
   );
      reached = (cnt >= lim - 1);
   endfunction

   // monitor level of a state; off and deep sleep read as unpowered
   function automatic logic is_powered
   (
      input mpsc_pkg::mpsc_state_t st
   );
      case (st)
         mpsc_pkg::MPSC_POR,
         mpsc_pkg::MPSC_ON,
         mpsc_pkg::MPSC_DETACH,
         mpsc_pkg::MPSC_RESET:
            is_powered = 1'b1;
         default:
            is_powered = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_d   = state_q;
      tmr_d     = tmr_q;
      sleep_d   = sleep_q;
      det_d     = 1'b0;
      // saturate so a key held for minutes never wraps and fires twice
      if (!pins.key_n && key_cnt_q != '1)
         key_cnt_d = key_cnt_q + 1'b1;
      else if (!pins.key_n)
         key_cnt_d = key_cnt_q;
      else
         key_cnt_d = '0;
      case (state_q)
         mpsc_pkg::MPSC_OFF:
         begin
            // only a long key press leaves off
            if (reached(key_cnt_q, ON_CYC))
            begin
               state_d = mpsc_pkg::MPSC_POR;
               tmr_d   = '0;
            end
         end
         mpsc_pkg::MPSC_POR:
         begin
            // own reset pulse on the shutdown line; host line ignored meanwhile
            tmr_d = tmr_q + 1'b1;
            if (reached(tmr_q, POR_CYC))
            begin
               state_d   = mpsc_pkg::MPSC_ON;
               key_cnt_d = '0;
            end
         end
         mpsc_pkg::MPSC_ON:
         begin
            sleep_d = sleep_request;
            // hard shutdown wins over every other request
            if (!pins.hard_shutdown_n)
               state_d = mpsc_pkg::MPSC_RESET;
            else if (software_shutdown_command || reached(key_cnt_q, OFF_CYC))
            begin
               state_d = mpsc_pkg::MPSC_DETACH;
               det_d   = 1'b1;
               tmr_d   = '0;
            end
            else if (psm_enable && psm_timer_expired)
            begin
               state_d   = mpsc_pkg::MPSC_PSM;
               key_cnt_d = '0;
            end
         end
         mpsc_pkg::MPSC_DETACH:
         begin
            // detach completes before the supply goes away unless hard shutdown cuts it short
            sleep_d = 1'b0;
            tmr_d   = tmr_q + 1'b1;
            if (!pins.hard_shutdown_n)
               state_d = mpsc_pkg::MPSC_RESET;
            else if (reached(tmr_q, DETACH_CYC))
            begin
               state_d   = mpsc_pkg::MPSC_OFF;
               key_cnt_d = '0;
            end
         end
         mpsc_pkg::MPSC_PSM:
         begin
            // shutdown line not looked at here
            sleep_d = 1'b0;
            if (psm_wake_due || reached(key_cnt_q, ON_CYC))
            begin
               state_d   = mpsc_pkg::MPSC_ON;
               key_cnt_d = '0;
            end
         end
         mpsc_pkg::MPSC_RESET:
         begin
            sleep_d = 1'b0;
            // released: straight to off, no detach; key ignored while held
            if (pins.hard_shutdown_n)
            begin
               state_d   = mpsc_pkg::MPSC_OFF;
               key_cnt_d = '0;
            end
         end
         // illegal code: fall back to off
         default:
            state_d = mpsc_pkg::MPSC_OFF;
      endcase

      // monitor tracks power only; no command input reaches it
      mon_d    = is_powered(state_d);
      aux_d    = mon_d || (state_d == mpsc_pkg::MPSC_PSM && !psm_enable);
      rst_d    = (state_d == mpsc_pkg::MPSC_RESET);
      por_oe_d = (state_d == mpsc_pkg::MPSC_POR);
      psm_d    = (state_d == mpsc_pkg::MPSC_PSM);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // plain reset lands in off; a fresh press is needed after any reset
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q   <= mpsc_pkg::MPSC_OFF;
         key_cnt_q <= '0;
         tmr_q     <= '0;
         sleep_q   <= 1'b0;
         mon_q     <= 1'b0;
         aux_q     <= 1'b0;
         det_q     <= 1'b0;
         rst_q     <= 1'b0;
         por_oe_q  <= 1'b0;
         psm_q     <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         key_cnt_q <= key_cnt_d;
         tmr_q     <= tmr_d;
         sleep_q   <= sleep_d;
         mon_q     <= mon_d;
         aux_q     <= aux_d;
         det_q     <= det_d;
         rst_q     <= rst_d;
         por_oe_q  <= por_oe_d;
         psm_q     <= psm_d;
      end
   end

   // pins and status all straight from flops, so nothing glitches
   assign pins.power_monitor_out     = mon_q;
   assign pins.aux_supply_out        = aux_q;
   // only ever pulls the shutdown line low, never drives it high
   assign pins.hard_shutdown_n_dev_o = 1'b0;
   assign pins.hard_shutdown_n_dev_oe = por_oe_q;
   assign detach_request = det_q;
   assign in_reset       = rst_q;
   assign in_sleep       = sleep_q;
   assign in_psm         = psm_q;

endmodule

// >>> src/mpsc_host.sv
`timescale 1ns/1ps
module mpsc_host #(
   parameter int unsigned ON_CYC     = mpsc_pkg::ON_CYC,
   parameter int unsigned OFF_CYC    = mpsc_pkg::OFF_CYC,
   parameter int unsigned HSD_CYC    = mpsc_pkg::HSD_CYC,
   parameter int unsigned MARGIN_CYC = mpsc_pkg::MARGIN_CYC
)(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // pins
   mpsc_if.host      pins,
   // user side
   input  wire logic power_on_req,
   input  wire logic power_off_req,
   input  wire logic wake_req,
   input  wire logic emergency_req,
   input  wire logic supply_ok,
   output logic      busy,
   output logic      module_powered
);

   mpsc_pkg::mpsc_host_state_t st_q, st_d;
   logic [mpsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [mpsc_pkg::CNT_W-1:0] len_q, len_d;
   logic                       key_oe_q, key_oe_d;
   logic                       hsd_oe_q, hsd_oe_d;
   logic                       pwr_q;
   logic                       busy_q;

   // ----------------------------------------
   // pulse sequencer
   // ----------------------------------------
   always_comb
   begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      len_d    = len_q;
      key_oe_d = key_oe_q;
      hsd_oe_d = hsd_oe_q;
      case (st_q)
         mpsc_pkg::MPSC_H_IDLE:
         begin
            cnt_d = '0;
            // emergency exit only on request; never part of normal flow
            if (emergency_req && pins.power_monitor_out)
            begin
               st_d     = mpsc_pkg::MPSC_H_HSD;
               len_d    = HSD_CYC + MARGIN_CYC;
               hsd_oe_d = 1'b1;
            end
            else if ((power_on_req || wake_req) && supply_ok)
            begin
               st_d     = mpsc_pkg::MPSC_H_KEY;
               len_d    = ON_CYC + MARGIN_CYC;
               key_oe_d = 1'b1;
            end
            else if (power_off_req)
            begin
               st_d     = mpsc_pkg::MPSC_H_KEY;
               len_d    = OFF_CYC + MARGIN_CYC;
               key_oe_d = 1'b1;
            end
         end
         mpsc_pkg::MPSC_H_KEY, mpsc_pkg::MPSC_H_HSD:
         begin
            // requests ignored until the pulse ends
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= len_q - 1)
            begin
               st_d     = mpsc_pkg::MPSC_H_IDLE;
               key_oe_d = 1'b0;
               hsd_oe_d = 1'b0;
            end
         end
         default:
            st_d = mpsc_pkg::MPSC_H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q     <= mpsc_pkg::MPSC_H_IDLE;
         cnt_q    <= '0;
         len_q    <= '0;
         key_oe_q <= 1'b0;
         hsd_oe_q <= 1'b0;
         pwr_q    <= 1'b0;
         busy_q   <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         len_q    <= len_d;
         key_oe_q <= key_oe_d;
         hsd_oe_q <= hsd_oe_d;
         pwr_q    <= pins.power_monitor_out;
         busy_q   <= (st_d != mpsc_pkg::MPSC_H_IDLE);
      end
   end

   // open drain: only ever pull low, no high drive
   assign pins.key_host_o             = 1'b0;
   assign pins.key_host_oe            = key_oe_q;
   assign pins.hard_shutdown_n_host_o  = 1'b0;
   assign pins.hard_shutdown_n_host_oe = hsd_oe_q;
   assign busy           = busy_q;
   assign module_powered = pwr_q;

endmodule

// >>> tb/mpsc_asserts.sv
`timescale 1ns/1ps
module mpsc_asserts #(
   parameter int ON_CYC     = 20,
   parameter int OFF_CYC    = 12,
   parameter int DETACH_CYC = 6
)(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // wires
   input wire logic key_n,
   input wire logic hard_shutdown_n,
   input wire logic hard_shutdown_n_dev_oe,
   input wire logic key_host_oe,
   input wire logic hard_shutdown_n_host_oe,
   input wire logic power_monitor_out
);
   localparam int D_MAX = DETACH_CYC + 4;
   logic [31:0] kcnt_q;
   logic [31:0] kcnt_d;
   // length of the current key press
   always_comb kcnt_d = key_n ? 32'h0 : kcnt_q + 32'h1;
   always_ff @(posedge sys_clk or posedge sys_rst)
      if (sys_rst)
         kcnt_q <= 32'h0;
      else
         kcnt_q <= kcnt_d;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_press_powers_on: assert property (!power_monitor_out && kcnt_q == ON_CYC
      |-> ##[0:3] power_monitor_out) else $error("no power-on after long press");
   a_no_early_on: assert property ($rose(power_monitor_out) && !key_n
      |-> kcnt_q >= ON_CYC - 2) else $error("power-on before full press");
   a_off_detach: assert property (power_monitor_out && kcnt_q == OFF_CYC
      |-> power_monitor_out [*5] ##[1:D_MAX] !power_monitor_out) else $error("bad power-off");
   a_hsd_holds: assert property (power_monitor_out && !hard_shutdown_n
      && !hard_shutdown_n_dev_oe |=> power_monitor_out) else $error("monitor fell in reset");
   a_hsd_release_off: assert property ($rose(hard_shutdown_n)
      && !$past(hard_shutdown_n_dev_oe) && $past(power_monitor_out)
      |-> ##[0:3] !power_monitor_out) else $error("no turn-off after release");
   a_hsd_ignored: assert property (!power_monitor_out && !hard_shutdown_n && key_n
      |=> !power_monitor_out) else $error("shutdown acted while unpowered");
   a_hsd_pulse_len: assert property ($rose(hard_shutdown_n_host_oe)
      |-> hard_shutdown_n_host_oe [*8]) else $error("shutdown pulse too short");
   a_key_pulse_len: assert property ($rose(key_host_oe)
      |-> key_host_oe [*8]) else $error("key pulse too short");
endmodule

// >>> tb/test_module_power_state_control.sv
`timescale 1ns/1ps
module test_module_power_state_control;
   localparam int unsigned ON = 20, OFF = 12, HSD = 8, POR = 4, DET = 6, MRG = 3;
   logic sys_clk = 0, sys_rst = 1, swc = 0, psm_en = 0, psm_exp = 0, wake_due = 0;
   logic on_r = 0, off_r = 0, wake_r = 0, emg_r = 0, sup_ok = 1;
   logic det, in_rst, in_psm, busy, powered, por_seen, rst_seen;
   int n_errors = 0, n_checks = 0, n_det, klen, klast, hlen, hlast, cyc, r;
   // op, monitor and aux after it, detach pulses
   int rows[12][3] = '{'{0,1,0}, '{1,0,1}, '{0,1,0}, '{3,0,1}, '{0,1,0}, '{2,0,0},
                       '{0,1,0}, '{4,0,0}, '{5,1,0}, '{4,0,0}, '{6,1,0}, '{1,0,1}};
   mpsc_if mpsc_if_i ();
   mpsc_device #(.ON_CYC(ON), .OFF_CYC(OFF), .POR_CYC(POR), .DETACH_CYC(DET)) mpsc_device_i
      (.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(mpsc_if_i), .software_shutdown_command(swc),
       .psm_enable(psm_en), .psm_timer_expired(psm_exp), .psm_wake_due(wake_due),
       .sleep_request(1'b0), .detach_request(det), .in_reset(in_rst), .in_sleep(),
       .in_psm(in_psm));
   mpsc_host #(.ON_CYC(ON), .OFF_CYC(OFF), .HSD_CYC(HSD), .MARGIN_CYC(MRG)) mpsc_host_i
      (.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(mpsc_if_i), .power_on_req(on_r),
       .power_off_req(off_r), .wake_req(wake_r), .emergency_req(emg_r), .supply_ok(sup_ok),
       .busy(busy), .module_powered(powered));
   mpsc_asserts #(.ON_CYC(ON), .OFF_CYC(OFF), .DETACH_CYC(DET)) mpsc_asserts_i
      (.sys_clk(sys_clk), .sys_rst(sys_rst), .key_n(mpsc_if_i.key_n),
       .hard_shutdown_n(mpsc_if_i.hard_shutdown_n),
       .hard_shutdown_n_dev_oe(mpsc_if_i.hard_shutdown_n_dev_oe),
       .key_host_oe(mpsc_if_i.key_host_oe),
       .hard_shutdown_n_host_oe(mpsc_if_i.hard_shutdown_n_host_oe),
       .power_monitor_out(mpsc_if_i.power_monitor_out));
   always #10 sys_clk = ~sys_clk;
   // ----------------
   // wire watcher
   // ----------------
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc > 6000)
      begin
         n_errors++;
         test_done();
      end
      if (det === 1'b1) n_det++;
      if (in_rst === 1'b1) rst_seen = 1;
      if (mpsc_if_i.hard_shutdown_n_dev_oe === 1'b1) por_seen = 1;
      if (mpsc_if_i.key_n === 1'b0) klen++;
      else if (klen > 0)
      begin
         klast = klen;
         klen = 0;
      end
      if (mpsc_if_i.hard_shutdown_n === 1'b0) hlen++;
      else if (hlen > 0)
      begin
         hlast = hlen;
         hlen = 0;
      end
   end
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic go(input int op);
      tick();
      n_det = 0;
      por_seen = 0;
      rst_seen = 0;
      case (op)
         0: on_r = 1;
         1: off_r = 1;
         2: emg_r = 1;
         3: swc = 1;
         4: {psm_en, psm_exp} = 2'b11;
         5: wake_r = 1;
         default: wake_due = 1;
      endcase
      tick();
      {on_r, off_r, emg_r, swc, psm_exp, wake_r, wake_due} = 7'h00;
   endtask
   // settle: monitor reaches its level, host idle, power-on reset over
   task automatic settle(input logic e);
      for (int i = 0; i < 80 && mpsc_if_i.power_monitor_out !== e; i++) tick();
      for (int i = 0; i < 80 && busy !== 1'b0; i++) tick();
      repeat (POR + 2) tick();
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge sys_clk);
      #1 sys_rst = 0;
      for (r = 0; r < 12; r++)
      begin
         go(rows[r][0]);
         settle(rows[r][1][0]);
         chk(mpsc_if_i.power_monitor_out, rows[r][1]);
         chk(mpsc_if_i.aux_supply_out, rows[r][1]);
         chk(powered, rows[r][1]);
         chk(n_det, rows[r][2]);
         case (rows[r][0])
            0: chk(por_seen, 1);
            1: chk(klast >= OFF, 1);
            2: chk({rst_seen, hlast >= HSD}, 2'h3);
            4: chk(in_psm, 1);
            default: ;
         endcase
      end
      // emergency request while off: module never enters reset, monitor stays low
      go(2);
      settle(1'b0);
      chk({rst_seen, mpsc_if_i.power_monitor_out}, 2'h0);
      // low supply: power-on request refused
      sup_ok = 0;
      go(0);
      repeat (ON + MRG + 4) tick();
      chk(mpsc_if_i.power_monitor_out, 0);
      sup_ok = 1;
      // off request overlapping a power-on press is dropped
      go(0);
      go(1);
      settle(1'b1);
      chk(mpsc_if_i.power_monitor_out, 1);
      // reset in the middle of a power-off press
      go(1);
      repeat (5) tick();
      sys_rst = 1;
      tick();
      chk({busy, mpsc_if_i.power_monitor_out, mpsc_if_i.key_n}, 3'h1);
      sys_rst = 0;
      tick();
      test_done();
   end
endmodule
